// ===== shared/gdfs_regs.svh
// Register offsets, field positions and reset values of the fault status bank.
`ifndef GDFS_REGS_SVH
`define GDFS_REGS_SVH
`define GDFS_ADDR_W            8
`define GDFS_GATE_FAULT_OFS    8'he0
`define GDFS_CTRL_FAULT_OFS    8'he2
`define GDFS_IRQ_STATUS_OFS    8'hf0
`define GDFS_IRQ_ENABLE_OFS    8'hf4
`define GDFS_IRQ_CLEAR_OFS     8'hf8
`define GDFS_RESET_VALUE       32'h00000000
`define GDFS_BIT_SUMMARY       31
`define GDFS_BIT_REG_FAULT     30
`define GDFS_BIT_OVERCURRENT   28
`define GDFS_BIT_RESET_ABSENT  27
`define GDFS_BIT_OVERVOLTAGE   26
`define GDFS_BIT_TEMP_ALARM    25
`define GDFS_BIT_TEMP_WARN     23
`define GDFS_BIT_TEMP_SHUT     22
`define GDFS_BIT_SWITCH_LO     16
`define GDFS_BIT_OTP_ERR       14
`define GDFS_BIT_REG_OC        13
`define GDFS_BIT_REG_UV        12
`define GDFS_BIT_CP_UV         11
`define GDFS_NUM_SWITCHES      6
`define GDFS_NUM_EVENTS        8
`endif

// ===== shared/gdfs_pkg.sv
// Types shared by the fault status bank.
package gdfs_pkg;
   typedef struct packed {
      logic [31:0] read_data;
      logic        irq;
      logic        fault_indicator_pin_low;
   } gdfs_out_type;
endpackage

// ===== logic/gdfs_sync.sv
// Two-flop synchroniser bank for asynchronous fault detector levels.
`timescale 1ns/10ps
`default_nettype none
module gdfs_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } gdfs_sync_state_type;

   gdfs_sync_state_type state_reg;
   gdfs_sync_state_type state_next;

   always_comb begin
      state_next        = state_reg;
      state_next.stage1 = async_in;
      state_next.stage2 = state_reg.stage1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.stage2;
endmodule
`default_nettype wire

// ===== logic/gdfs_fault_bank.sv
// Gate-drive fault status register bank with its event interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "gdfs_regs.svh"
module gdfs_fault_bank
   import gdfs_pkg::*;
#(
   parameter logic [31:0] CTRL_FAULT_VALUE_MASK = 32'hffffc00f
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   output logic             irq,
   output logic             fault_indicator_pin_low,
   input  wire logic        regulator_fault_flag,
   input  wire logic        supply_reset_detected,
   input  wire logic        supply_overvoltage_flag,
   input  wire logic        temp_warning_flag,
   input  wire logic        temp_shutdown_flag,
   input  wire logic        phase_c_high_switch_overcurrent,
   input  wire logic        phase_c_low_switch_overcurrent,
   input  wire logic        phase_b_high_switch_overcurrent,
   input  wire logic        phase_b_low_switch_overcurrent,
   input  wire logic        phase_a_high_switch_overcurrent,
   input  wire logic        phase_a_low_switch_overcurrent,
   input  wire logic        otp_error_flag,
   input  wire logic        regulator_overcurrent,
   input  wire logic        regulator_undervoltage,
   input  wire logic        charge_pump_undervoltage,
   input  wire logic [31:0] control_fault_in
);
   localparam int NSW  = `GDFS_NUM_SWITCHES;
   localparam int NEV  = `GDFS_NUM_EVENTS;
   localparam int NRAW = 9 + NSW;

   typedef struct packed {
      logic [31:0]    gate_drive_fault_flags;
      logic [31:0]    control_fault_flags;
      logic [NEV-1:0] irq_status;
      logic [NEV-1:0] irq_enable;
      logic [NEV-1:0] event_prev;
      logic           started;
      gdfs_out_type   out;
   } gdfs_state_type;

   gdfs_state_type state_reg;
   gdfs_state_type state_next;

   logic [NRAW-1:0] raw_async;
   logic [NRAW-1:0] raw_sync;
   logic [31:0]     ctrl_sync;
   logic [NSW-1:0]  switch_oc;
   logic [NEV-1:0]  event_level;
   logic [31:0]     gate_word;

   // All detector levels come from analog comparators outside this clock domain.
   assign raw_async = {phase_c_high_switch_overcurrent, phase_c_low_switch_overcurrent,
                       phase_b_high_switch_overcurrent, phase_b_low_switch_overcurrent,
                       phase_a_high_switch_overcurrent, phase_a_low_switch_overcurrent,
                       charge_pump_undervoltage, regulator_undervoltage,
                       regulator_overcurrent, otp_error_flag,
                       temp_shutdown_flag, temp_warning_flag,
                       supply_overvoltage_flag, supply_reset_detected,
                       regulator_fault_flag};

   gdfs_sync #(
      .WIDTH (NRAW)
   ) u_sync_gate (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in (raw_async),
      .sync_out (raw_sync)
   );

   gdfs_sync #(
      .WIDTH (32)
   ) u_sync_ctrl (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in (control_fault_in),
      .sync_out (ctrl_sync)
   );

   // Switch order low to high: A low, A high, B low, B high, C low, C high.
   assign switch_oc = raw_sync[NRAW-1 -: NSW];

   always_comb begin
      gate_word = `GDFS_RESET_VALUE;
      gate_word[`GDFS_BIT_REG_FAULT] = raw_sync[0];
      gate_word[`GDFS_BIT_OVERCURRENT] = |switch_oc;
      gate_word[`GDFS_BIT_RESET_ABSENT] = ~raw_sync[1];
      gate_word[`GDFS_BIT_OVERVOLTAGE] = raw_sync[2];
      gate_word[`GDFS_BIT_TEMP_ALARM] = raw_sync[3] | raw_sync[4];
      gate_word[`GDFS_BIT_TEMP_WARN] = raw_sync[3];
      gate_word[`GDFS_BIT_TEMP_SHUT] = raw_sync[4];
      gate_word[`GDFS_BIT_OTP_ERR] = raw_sync[5];
      gate_word[`GDFS_BIT_REG_OC] = raw_sync[6];
      gate_word[`GDFS_BIT_REG_UV] = raw_sync[7];
      gate_word[`GDFS_BIT_CP_UV] = raw_sync[8];
      gate_word[`GDFS_BIT_SWITCH_LO +: NSW] = switch_oc;
      // The summary leaves out bit 27, which reads 1 in a healthy part.
      gate_word[`GDFS_BIT_SUMMARY] = |{gate_word[30:28], gate_word[26:0]};
   end

   // Events: summary, regulator, overcurrent, reset, overvoltage, temp, memory, pump.
   assign event_level = {gate_word[`GDFS_BIT_CP_UV], gate_word[`GDFS_BIT_OTP_ERR],
                         gate_word[`GDFS_BIT_TEMP_ALARM], gate_word[`GDFS_BIT_OVERVOLTAGE],
                         ~gate_word[`GDFS_BIT_RESET_ABSENT],
                         gate_word[`GDFS_BIT_OVERCURRENT],
                         gate_word[`GDFS_BIT_REG_FAULT], gate_word[`GDFS_BIT_SUMMARY]};

   always_comb begin
      state_next = state_reg;
      state_next.started = 1'b1;
      // Status words hold their reset value for one clock after reset, one clock less than the synchronisers take to fill.
      if (state_reg.started) begin
         state_next.gate_drive_fault_flags = gate_word;
         state_next.control_fault_flags = ctrl_sync & CTRL_FAULT_VALUE_MASK;
      end
      state_next.event_prev = event_level;
      state_next.out.fault_indicator_pin_low = ~gate_word[`GDFS_BIT_SUMMARY];
      // A clear write loses against a rising edge in the same cycle.
      if (reg_write && reg_addr == `GDFS_IRQ_CLEAR_OFS) begin
         state_next.irq_status = state_reg.irq_status & ~reg_wdata[NEV-1:0];
      end
      if (reg_write && reg_addr == `GDFS_IRQ_ENABLE_OFS) begin
         state_next.irq_enable = reg_wdata[NEV-1:0];
      end
      state_next.irq_status = state_next.irq_status | (event_level & ~state_reg.event_prev);
      state_next.out.irq = |(state_next.irq_status & state_next.irq_enable);
      // Writes to the two status words fall through every branch and change nothing.
      state_next.out.read_data = `GDFS_RESET_VALUE;
      if (reg_read) begin
         case (reg_addr)
            `GDFS_GATE_FAULT_OFS: state_next.out.read_data = state_reg.gate_drive_fault_flags;
            `GDFS_CTRL_FAULT_OFS: state_next.out.read_data = state_reg.control_fault_flags;
            `GDFS_IRQ_STATUS_OFS: state_next.out.read_data = {24'h000000, state_reg.irq_status};
            `GDFS_IRQ_ENABLE_OFS: state_next.out.read_data = {24'h000000, state_reg.irq_enable};
            default: state_next.out.read_data = `GDFS_RESET_VALUE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.out.fault_indicator_pin_low <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata = state_reg.out.read_data;
   assign irq = state_reg.out.irq;
   assign fault_indicator_pin_low = state_reg.out.fault_indicator_pin_low;
endmodule
`default_nettype wire

// ===== dv/gdfs_fault_bank_monitor.sv
// Port-level checker of the fault status bank.
`timescale 1ns/10ps
`default_nettype none
module gdfs_monitor #(
   parameter logic [31:0] CTRL_FAULT_VALUE_MASK = 32'hffffc00f
) (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic        irq,
   input wire logic        fault_indicator_pin_low
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence gate_rd; reg_read && reg_addr == 8'he0; endsequence
   sequence ctrl_rd; reg_read && reg_addr == 8'he2; endsequence
   a_pin_mirror: assert property (gate_rd |=> reg_rdata[31] == !$past(fault_indicator_pin_low))
      else $error("summary bit differs from fault pin");
   a_summary_or: assert property (gate_rd |=> reg_rdata[31] == |(reg_rdata & 32'h77ffffff))
      else $error("summary bit is not the OR of the fault bits");
   a_reserved_zero: assert property (gate_rd |=> (reg_rdata & 32'h210087ff) == 32'h0)
      else $error("reserved gate bits not zero");
   a_temp_alarm_or: assert property (gate_rd |=> reg_rdata[25] == (reg_rdata[23] | reg_rdata[22]))
      else $error("temperature alarm is not warning or shutdown");
   a_overcurrent_or: assert property (gate_rd |=> reg_rdata[28] == |reg_rdata[21:16])
      else $error("overcurrent bit is not the OR of the switch bits");
   a_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data present without a read");
   a_unmapped_zero: assert property (reg_read && !(reg_addr inside {8'he0, 8'he2, 8'hf0, 8'hf4})
      |=> reg_rdata == 32'h0) else $error("unmapped read returned data");
   a_ctrl_reserved: assert property (ctrl_rd |=> (reg_rdata & ~CTRL_FAULT_VALUE_MASK) == 32'h0)
      else $error("reserved controller bits not zero");
   a_irq_masked: assert property (reg_write && reg_addr == 8'hf4 && reg_wdata == 32'h0
      |-> ##[1:2] !irq) else $error("interrupt stays high with enables off");
endmodule
`default_nettype wire

// ===== dv/gdfs_host.sv
// Host software model issuing register reads and writes.
`timescale 1ns/10ps
`default_nettype none
module gdfs_host (
   input  wire logic        ref_clk,
   input  wire logic [31:0] reg_rdata,
   output logic      [7:0]  reg_addr = 8'h00,
   output logic      [31:0] reg_wdata = 32'h0,
   output logic             reg_write = 1'b0,
   output logic             reg_read = 1'b0
);
   // Data is inverted after a write so stale bus contents never pass for live data.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      // Read data stand for the whole next cycle and are taken at its closing edge.
      @(posedge ref_clk);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== dv/gdfs_fault_bank_tb_top.sv
// Testbench top of the fault status bank.
`timescale 1ns/10ps
`default_nettype none
module gdfs_fault_bank_tb_top;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, got, e, r;
   logic [31:0] ctrl = 32'h0;
   logic        reg_write, reg_read, irq, pin_low;
   logic [14:0] f = 15'h0000;
   logic [31:0] seed = 32'h94b6;
   int          n_errors = 0;
   int          checks = 0;
   gdfs_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
   gdfs_fault_bank uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .irq(irq), .fault_indicator_pin_low(pin_low), .regulator_fault_flag(f[0]),
      .supply_reset_detected(f[1]), .supply_overvoltage_flag(f[2]), .temp_warning_flag(f[3]),
      .temp_shutdown_flag(f[4]), .phase_c_high_switch_overcurrent(f[5]),
      .phase_c_low_switch_overcurrent(f[6]), .phase_b_high_switch_overcurrent(f[7]),
      .phase_b_low_switch_overcurrent(f[8]), .phase_a_high_switch_overcurrent(f[9]),
      .phase_a_low_switch_overcurrent(f[10]), .otp_error_flag(f[11]),
      .regulator_overcurrent(f[12]), .regulator_undervoltage(f[13]),
      .charge_pump_undervoltage(f[14]), .control_fault_in(ctrl));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] exp_word(input logic [14:0] v);
      logic [31:0] w;
      w = {1'b0, v[0], 1'b0, |v[10:5], ~v[1], v[2], v[3] | v[4], 1'b0, v[3], v[4], v[5], v[6],
           v[7], v[8], v[9], v[10], 1'b0, v[11], v[12], v[13], v[14], 11'h000};
      w[31] = |(w & 32'h77ffffff);
      return w;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wait_irq(input logic lvl);
      int k;
      for (k = 0; k < 20 && irq !== lvl; k++) @(posedge ref_clk);
      check("irq", {31'h0, irq}, {31'h0, lvl});
      if (irq !== lvl) report_and_stop();
   endtask
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      host.rd(8'he0, got);
      check("gate_reset", got, 32'h0);
      host.rd(8'he2, got);
      check("ctrl_reset", got, 32'h0);
      for (int i = 0; i < 24; i++) begin
         r = rnd();
         f <= (i == 0) ? 15'h7fff : (i == 1) ? 15'h0002 : (i == 2) ? 15'h0000 : r[14:0];
         ctrl <= rnd();
         repeat (5) @(posedge ref_clk);
         e = exp_word(f);
         host.rd(8'he0, got);
         check("gate", got, e);
         check("pin_low", {31'h0, pin_low}, {31'h0, ~e[31]});
         host.rd(8'he2, got);
         check("ctrl", got, ctrl & 32'hffffc00f);
      end
      host.wr(8'he0, 32'hffffffff);
      host.wr(8'he2, 32'hffffffff);
      host.rd(8'he0, got);
      check("gate_after_write", got, e);
      host.rd(8'h10, got);
      check("unmapped", got, 32'h0);
      f <= 15'h0002;
      host.wr(8'hf4, 32'h00000001);
      host.rd(8'hf4, got);
      check("irq_enable", got, 32'h00000001);
      repeat (5) @(posedge ref_clk);
      host.wr(8'hf8, 32'h000000ff);
      wait_irq(1'b0);
      f <= 15'h0001;
      wait_irq(1'b1);
      host.rd(8'hf0, got);
      check("irq_status", got & 32'h1, 32'h1);
      host.wr(8'hf8, 32'h00000001);
      wait_irq(1'b0);
      host.wr(8'hf4, 32'h00000000);
      f <= 15'h0000;
      repeat (5) @(posedge ref_clk);
      f <= 15'h0001;
      repeat (6) @(posedge ref_clk);
      check("irq_masked", {31'h0, irq}, 32'h0);
      host.rd(8'hf0, got);
      check("status_masked", got & 32'h1, 32'h1);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      host.rd(8'he0, got);
      check("gate_reset_again", got, 32'h0);
      report_and_stop();
   end
endmodule
bind gdfs_fault_bank gdfs_monitor #(.CTRL_FAULT_VALUE_MASK(CTRL_FAULT_VALUE_MASK)) mon (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
   .fault_indicator_pin_low(fault_indicator_pin_low));
`default_nettype wire
